// >>> verilog/dsad_pkg.sv
// Constants for the DMA sniffer, abort and debug register block.
// Assumes a 32-bit AHB-Lite slave decoding the low 12 address bits.
//
// Functional notes
// [R01] Calculation_select code 0x0 is CRC-32 IEEE, 0x1 the same on bit-reversed data.
// [R02] Calculation_select code 0x2 is CRC-16-CCITT, 0x3 the same on bit-reversed data.
// [R03] Calculation_select code 0xe XOR-reduces all data; result one when population odd.
// [R04] Calculation_select code 0xf adds each word into a 32-bit accumulator.
// [R05] Sniff only the selected channel, only while enabled; both reset zero.
// [R06] Software seeds the accumulator before the transfer; it resets to zero.
// [R07] Each read of the observed channel folds its data into the accumulator.
// [R08] After the transfer the accumulator holds the result at 0x438.
// [R09] Levels register shows read-address, write-address, data queue levels.
// [R10] Writing one to an abort bit aborts that channel's sequence.
// [R11] Abort bit reads one until in-flight transfers flush, then self-clears.
// [R12] Software polls abort until zero before restarting the channel.
// [R13] Bits 4:0 of the count register report the built channel count.
// [R14] Channel count is a parameter from one to sixteen.
// [R15] Debug counter read returns expected peripheral accesses in bits 5:0.
// [R16] Any write to a debug counter clears it and restarts the handshake.
// [R17] Debug counters sit at 0x800 with a 0x40 stride per channel.
// [R18] Result invert bit 11 complements the read value only.
// [R19] Result reverse bit 10 bit-reverses the read value only.
// [R20] Byte swap bit 9 byte-reverses observed data before calculation.
// [R21] Reserved calculation_select codes hold the accumulator.

`default_nettype none

package dsad_pkg;

  localparam logic [11:0] SNIFF_CONTROL_OFS     = 12'h434;
  localparam logic [11:0] SNIFF_ACCUMULATOR_OFS = 12'h438;
  localparam logic [11:0] FIFO_FILL_LEVELS_OFS  = 12'h440;
  localparam logic [11:0] CHANNEL_ABORT_OFS     = 12'h444;
  localparam logic [11:0] CHANNEL_COUNT_OFS     = 12'h448;
  localparam logic [11:0] REQ_COUNTER_BASE_OFS  = 12'h800;
  localparam int          REQ_COUNTER_STRIDE_LG = 6;

  localparam int ENABLE_BIT     = 0;
  localparam int CHAN_SEL_LSB   = 1;
  localparam int CALCULATION_SELECT_SEL_LSB   = 5;
  localparam int BYTE_SWAP_BIT  = 9;
  localparam int RES_REV_BIT    = 10;
  localparam int RES_INV_BIT    = 11;
  localparam int CONTROL_WIDTH  = 12;
  localparam int TDF_LSB        = 0;
  localparam int WAF_LSB        = 8;
  localparam int RAF_LSB        = 16;
  localparam int REQ_CNT_WIDTH  = 6;

  localparam logic [11:0] SNIFF_CONTROL_RESET = 12'h000;
  localparam logic [31:0] ACCUMULATOR_RESET   = 32'h0000_0000;

  localparam logic [31:0] CRC32_POLY = 32'h04c1_1db7;
  localparam logic [15:0] CRC16_POLY = 16'h1021;

  typedef enum logic [3:0] {
    DSAD_CALCULATION_SELECT_CRC32     = 4'b0000,
    DSAD_CALCULATION_SELECT_CRC32_REV = 4'b0001,
    DSAD_CALCULATION_SELECT_CRC16     = 4'b0010,
    DSAD_CALCULATION_SELECT_CRC16_REV = 4'b0011,
    DSAD_CALCULATION_SELECT_PARITY    = 4'b1110,
    DSAD_CALCULATION_SELECT_SUM       = 4'b1111
  } dsad_calculation_select_t;

endpackage

`default_nettype wire

// >>> verilog/dsad_top.sv
// DMA sniffer, FIFO level, channel abort and request counter debug registers.
// Assumes an AHB-Lite master with single word transfers and channel logic
// that reports reads, in-flight transfers and peripheral request events.
//
// The AHB-Lite slave port is this design's own decision.

`timescale 1ns/10ps
`default_nettype none

module dsad_top #(
  parameter int NCH = 12 // R14
) (
  input  wire logic                      i_clock,
  input  wire logic                      i_arst_n,
  input  wire logic                      i_hsel,
  input  wire logic [31:0]               i_haddr,
  input  wire logic [1:0]                i_htrans,
  input  wire logic                      i_hwrite,
  input  wire logic [2:0]                i_hsize,
  input  wire logic [31:0]               i_hwdata,
  input  wire logic                      i_hready,
  output logic                           o_hreadyout,
  output logic                           o_hresp,
  output logic [31:0]                    o_hrdata,
  input  wire logic [NCH-1:0]            i_chan_read_valid,
  input  wire logic [NCH-1:0][31:0]      i_chan_read_data,
  input  wire logic [7:0]                i_read_addr_queue_level,
  input  wire logic [7:0]                i_write_addr_queue_level,
  input  wire logic [7:0]                i_transfer_data_queue_level,
  input  wire logic [NCH-1:0]            i_chan_inflight,
  output logic [NCH-1:0]                 o_channel_abort,
  input  wire logic [NCH-1:0]            i_peripheral_request,
  input  wire logic [NCH-1:0]            i_chan_peripheral_access,
  output logic [NCH-1:0]                 o_request_restart
);

  typedef struct packed {
    logic [31:0]                           acc;
    logic [dsad_pkg::CONTROL_WIDTH-1:0]    ctrl;
    logic [NCH-1:0]                        abort;
    logic [NCH-1:0][dsad_pkg::REQ_CNT_WIDTH-1:0] req_cnt;
    logic [NCH-1:0]                        restart;
    logic                                  dp_write;
    logic [11:0]                           dp_addr;
    logic [31:0]                           rdata;
    logic                                  ready;
    logic                                  resp;
  } dsad_state_t;

  dsad_state_t q;
  dsad_state_t n;

  function automatic logic [31:0] dsad_rev32(input logic [31:0] d);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      r[i] = d[31-i];
    end
    return r;
  endfunction

  function automatic logic [31:0] dsad_crc32(input logic [31:0] c_in, input logic [31:0] d);
    logic [31:0] c;
    logic        fb;
    c = c_in;
    fb = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      fb = c[31] ^ d[i];
      c = {c[30:0], 1'b0} ^ (fb ? dsad_pkg::CRC32_POLY : 32'h0000_0000);
    end
    return c;
  endfunction

  function automatic logic [15:0] dsad_crc16(input logic [15:0] c_in, input logic [31:0] d);
    logic [15:0] c;
    logic        fb;
    c = c_in;
    fb = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0} ^ (fb ? dsad_pkg::CRC16_POLY : 16'h0000);
    end
    return c;
  endfunction

  // Control fields
  logic                   sniff_enable;
  logic [3:0]             observed_channel_select;
  logic [3:0]             calculation_select;
  logic                   byte_swap;
  logic                   result_bit_reverse;
  logic                   result_invert;

  assign sniff_enable            = q.ctrl[dsad_pkg::ENABLE_BIT];
  assign observed_channel_select = q.ctrl[dsad_pkg::CHAN_SEL_LSB +: 4];
  assign calculation_select      = q.ctrl[dsad_pkg::CALCULATION_SELECT_SEL_LSB +: 4];
  assign byte_swap               = q.ctrl[dsad_pkg::BYTE_SWAP_BIT];
  assign result_bit_reverse      = q.ctrl[dsad_pkg::RES_REV_BIT];
  assign result_invert           = q.ctrl[dsad_pkg::RES_INV_BIT];

  // Address phase accepted this cycle
  logic addr_phase;
  assign addr_phase = i_hsel && i_htrans[1] && i_hready;

  // Debug counter decode helper
  function automatic logic dsad_is_dbg(input logic [11:0] a);
    return a[11] && (a[dsad_pkg::REQ_COUNTER_STRIDE_LG-1:0] == 6'h00)
           && (int'(a[9:6]) < NCH) && !a[10];
  endfunction

  always_comb begin
    logic [31:0] sdata;
    logic [31:0] result;
    logic        observed;
    logic [3:0]  wch;
    logic [3:0]  rch;
    logic [11:0] ra;
    sdata = '0;
    result = '0;
    observed = 1'b0;
    wch = q.dp_addr[9:6];
    rch = i_haddr[9:6];
    ra = {i_haddr[11:2], 2'b00};
    n = q;
    n.restart = '0;
    n.ready = 1'b1;
    n.resp = 1'b0;

    // Sniffer datapath
    if (int'(observed_channel_select) < NCH) begin
      observed = sniff_enable && i_chan_read_valid[observed_channel_select]; // R05
      sdata = i_chan_read_data[observed_channel_select];
    end
    if (byte_swap) begin
      sdata = {sdata[7:0], sdata[15:8], sdata[23:16], sdata[31:24]}; // R20
    end
    if (observed) begin // R07
      unique case (calculation_select)
        dsad_pkg::DSAD_CALCULATION_SELECT_CRC32:     n.acc = dsad_crc32(q.acc, sdata); // R01
        dsad_pkg::DSAD_CALCULATION_SELECT_CRC32_REV: n.acc = dsad_crc32(q.acc, dsad_rev32(sdata)); // R01
        dsad_pkg::DSAD_CALCULATION_SELECT_CRC16:     n.acc = {16'h0000, dsad_crc16(q.acc[15:0], sdata)}; // R02
        dsad_pkg::DSAD_CALCULATION_SELECT_CRC16_REV: begin
          n.acc = {16'h0000, dsad_crc16(q.acc[15:0], dsad_rev32(sdata))}; // R02
        end
        dsad_pkg::DSAD_CALCULATION_SELECT_PARITY:    n.acc = {31'h0000_0000, q.acc[0] ^ (^sdata)}; // R03
        dsad_pkg::DSAD_CALCULATION_SELECT_SUM:       n.acc = q.acc + sdata; // R04
        default:                       n.acc = q.acc; // R21
      endcase
    end

    // Abort bits clear once the channel has nothing in flight
    for (int c = 0; c < NCH; c++) begin
      if (q.abort[c] && !i_chan_inflight[c]) begin
        n.abort[c] = 1'b0; // R11
      end
    end

    // Expected peripheral accesses, saturating both ways
    for (int c = 0; c < NCH; c++) begin
      if (i_peripheral_request[c] && !i_chan_peripheral_access[c]
          && q.req_cnt[c] != 6'h3f) begin
        n.req_cnt[c] = q.req_cnt[c] + 6'h01;
      end else if (!i_peripheral_request[c] && i_chan_peripheral_access[c]
                   && q.req_cnt[c] != 6'h00) begin
        n.req_cnt[c] = q.req_cnt[c] - 6'h01;
      end
    end

    // Write data phase; software wins over the sniffer
    if (q.dp_write) begin
      if (q.dp_addr == dsad_pkg::SNIFF_CONTROL_OFS) begin
        n.ctrl = i_hwdata[dsad_pkg::CONTROL_WIDTH-1:0]; // R05
      end else if (q.dp_addr == dsad_pkg::SNIFF_ACCUMULATOR_OFS) begin
        n.acc = i_hwdata; // R06
      end else if (q.dp_addr == dsad_pkg::CHANNEL_ABORT_OFS) begin
        n.abort = n.abort | i_hwdata[NCH-1:0]; // R10
      end else if (dsad_is_dbg(q.dp_addr)) begin
        n.req_cnt[wch] = '0; // R16
        n.restart[wch] = 1'b1; // R16
      end
    end

    // Address phase capture
    n.dp_write = addr_phase && i_hwrite;
    n.dp_addr = addr_phase ? ra : q.dp_addr;

    // Read data built from the state seen in the data phase
    result = n.acc;
    if (n.ctrl[dsad_pkg::RES_REV_BIT]) begin
      result = dsad_rev32(result); // R19
    end
    if (n.ctrl[dsad_pkg::RES_INV_BIT]) begin
      result = ~result; // R18
    end
    n.rdata = '0;
    if (addr_phase && !i_hwrite) begin
      if (ra == dsad_pkg::SNIFF_CONTROL_OFS) begin
        n.rdata[dsad_pkg::CONTROL_WIDTH-1:0] = n.ctrl;
      end else if (ra == dsad_pkg::SNIFF_ACCUMULATOR_OFS) begin
        n.rdata = result; // R08
      end else if (ra == dsad_pkg::FIFO_FILL_LEVELS_OFS) begin
        n.rdata[dsad_pkg::RAF_LSB +: 8] = i_read_addr_queue_level; // R09
        n.rdata[dsad_pkg::WAF_LSB +: 8] = i_write_addr_queue_level; // R09
        n.rdata[dsad_pkg::TDF_LSB +: 8] = i_transfer_data_queue_level; // R09
      end else if (ra == dsad_pkg::CHANNEL_ABORT_OFS) begin
        n.rdata[NCH-1:0] = n.abort; // R11
      end else if (ra == dsad_pkg::CHANNEL_COUNT_OFS) begin
        n.rdata[4:0] = 5'(NCH); // R13
      end else if (dsad_is_dbg(ra)) begin
        n.rdata[dsad_pkg::REQ_CNT_WIDTH-1:0] = n.req_cnt[rch]; // R15 R17
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q.acc     <= dsad_pkg::ACCUMULATOR_RESET;
      q.ctrl    <= dsad_pkg::SNIFF_CONTROL_RESET;
      q.abort   <= '0;
      q.req_cnt <= '0;
      q.restart <= '0;
      q.dp_write <= 1'b0;
      q.dp_addr <= 12'h000;
      q.rdata   <= 32'h0000_0000;
      q.ready   <= 1'b1;
      q.resp    <= 1'b0;
    end else begin
      q <= n;
    end
  end

  assign o_hreadyout     = q.ready;
  assign o_hresp         = q.resp;
  assign o_hrdata        = q.rdata;
  assign o_channel_abort = q.abort;
  assign o_request_restart = q.restart;

  // Checks
  default clocking dsad_cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);

  logic rd_count;
  logic wr_abort0;
  logic wr_dbg0;
  logic wr_any;
  assign rd_count  = addr_phase && !i_hwrite && ({i_haddr[11:2], 2'b00} == dsad_pkg::CHANNEL_COUNT_OFS);
  assign wr_abort0 = q.dp_write && (q.dp_addr == dsad_pkg::CHANNEL_ABORT_OFS) && i_hwdata[0];
  assign wr_dbg0   = q.dp_write && (q.dp_addr == dsad_pkg::REQ_COUNTER_BASE_OFS);
  assign wr_any    = q.dp_write;

  logic [11:0] bus_word;
  logic        wr_ctrl;
  logic        wr_acc;
  logic        sniff_hit;
  assign bus_word  = {i_haddr[11:2], 2'b00};
  assign wr_ctrl   = q.dp_write && (q.dp_addr == dsad_pkg::SNIFF_CONTROL_OFS);
  assign wr_acc    = q.dp_write && (q.dp_addr == dsad_pkg::SNIFF_ACCUMULATOR_OFS);
  assign sniff_hit = sniff_enable && (int'(observed_channel_select) < NCH)
                     && i_chan_read_valid[observed_channel_select];

  sequence bus_read_s(logic [11:0] ofs);
    addr_phase && !i_hwrite && (bus_word == ofs);
  endsequence

  sequence abort_request_s;
    wr_abort0;
  endsequence

  sequence abort_seen_s;
    ##1 o_channel_abort[0];
  endsequence

  sequence restart_pulse_s;
    ##1 (o_request_restart[0] && q.req_cnt[0] == 6'h00) ##1 !o_request_restart[0];
  endsequence

  bus_okay_a: assert property (o_hreadyout && !o_hresp)
    else $error("Slave not ready or not OKAY");
  abort_set_a: assert property (abort_request_s |-> abort_seen_s) // R10
    else $error("Abort write did not set the channel bit");
  abort_hold_a: assert property (o_channel_abort[0] && i_chan_inflight[0] |=> o_channel_abort[0]) // R11
    else $error("Abort bit dropped while transfers in flight");
  abort_clear_a: assert property (o_channel_abort[0] && !i_chan_inflight[0] && !wr_abort0
                                  |=> !o_channel_abort[0]) // R11
    else $error("Abort bit did not self-clear");
  count_read_a: assert property (rd_count |=> o_hrdata == 32'(NCH)) // R13
    else $error("Channel count read wrong");
  dbg_restart_a: assert property (wr_dbg0 |-> restart_pulse_s) // R16
    else $error("Debug write did not clear and restart");
  sniff_off_a: assert property (!sniff_enable && !wr_any |=> $stable(q.acc)) // R05
    else $error("Accumulator moved while sniffer disabled");
  calculation_select_reserved_a: assert property (calculation_select inside {[4'h4:4'hd]} && !wr_any
                                    |=> $stable(q.acc)) // R21
    else $error("Accumulator moved on reserved code");
  checksum_a: assert property (sniff_enable && observed_channel_select == 4'h0 && !byte_swap
                               && calculation_select == 4'hf && i_chan_read_valid[0]
                               && !wr_any |=> q.acc == $past(q.acc) + $past(i_chan_read_data[0])) // R04
    else $error("Checksum did not add observed word");
  parity_a: assert property (sniff_enable && observed_channel_select == 4'h0
                             && calculation_select == 4'he && i_chan_read_valid[0] && !wr_any
                             |=> q.acc[0] == ($past(q.acc[0]) ^ (^$past(i_chan_read_data[0])))) // R03
    else $error("Parity reduction wrong");

  rdata_idle_a: assert property (!(addr_phase && !i_hwrite) |=> o_hrdata == 32'h0000_0000)
    else $error("Read data not zero outside a read");

  ctrl_write_a: assert property (wr_ctrl
                                 |=> q.ctrl == $past(i_hwdata[dsad_pkg::CONTROL_WIDTH-1:0])) // R05
    else $error("Control write not stored");

  ctrl_read_a: assert property (bus_read_s(dsad_pkg::SNIFF_CONTROL_OFS)
                                |=> o_hrdata == 32'(q.ctrl)) // R05
    else $error("Control read wrong");

  acc_seed_a: assert property (wr_acc |=> q.acc == $past(i_hwdata)) // R06
    else $error("Seed write not stored");

  acc_read_a: assert property (bus_read_s(dsad_pkg::SNIFF_ACCUMULATOR_OFS)
                               |=> o_hrdata == ((q.ctrl[dsad_pkg::RES_REV_BIT] ? dsad_rev32(q.acc)
                                                 : q.acc) ^ {32{q.ctrl[dsad_pkg::RES_INV_BIT]}})) // R08 R18 R19
    else $error("Accumulator read path wrong");

  levels_read_a: assert property (bus_read_s(dsad_pkg::FIFO_FILL_LEVELS_OFS)
                                  |=> o_hrdata == {8'h00, $past(i_read_addr_queue_level),
                                                   $past(i_write_addr_queue_level),
                                                   $past(i_transfer_data_queue_level)}) // R09
    else $error("Levels read wrong");

  abort_read_a: assert property (bus_read_s(dsad_pkg::CHANNEL_ABORT_OFS)
                                 |=> o_hrdata == 32'(o_channel_abort)) // R11
    else $error("Abort read does not match abort state");

  unmapped_read_a: assert property (bus_read_s(12'h500) |=> o_hrdata == 32'h0000_0000)
    else $error("Unmapped read not zero");

  dbg_read_a: assert property (bus_read_s(dsad_pkg::REQ_COUNTER_BASE_OFS)
                               |=> o_hrdata == 32'(q.req_cnt[0])) // R15 R17
    else $error("Debug counter read wrong");

  req_up_a: assert property (i_peripheral_request[0] && !i_chan_peripheral_access[0] && !wr_dbg0
                             && q.req_cnt[0] != 6'h3f
                             |=> q.req_cnt[0] == $past(q.req_cnt[0]) + 6'h01) // R15
    else $error("Request did not count up");

  req_down_a: assert property (!i_peripheral_request[0] && i_chan_peripheral_access[0] && !wr_dbg0
                               && q.req_cnt[0] != 6'h00
                               |=> q.req_cnt[0] == $past(q.req_cnt[0]) - 6'h01) // R15
    else $error("Access did not count down");

  restart_idle_a: assert property (!wr_any |=> o_request_restart == '0) // R16
    else $error("Restart pulse without a debug write");

  crc16_high_a: assert property (sniff_hit && calculation_select inside {4'h2, 4'h3} && !wr_any
                                 |=> q.acc[31:16] == 16'h0000) // R02
    else $error("CRC-16 upper half not clear");

  crc32_step_a: assert property (sniff_hit && observed_channel_select == 4'h0 && !byte_swap
                                 && calculation_select == 4'h0 && !wr_any
                                 |=> q.acc == dsad_crc32($past(q.acc),
                                                         $past(i_chan_read_data[0]))) // R01
    else $error("CRC-32 step wrong");

endmodule

`default_nettype wire

// >>> verification/dsad_chan_model.sv
// Channel-side model: channel reads, in-flight flags, peripheral pulses.
// Assumes one clock shared with the register block; the bench calls its tasks.
`timescale 1ns/10ps
`default_nettype none
module dsad_chan_model #(
  parameter int NCH = 12
) (
  input  wire logic             i_clock,
  output logic [NCH-1:0]        o_read_valid,
  output logic [NCH-1:0][31:0]  o_read_data,
  output logic [NCH-1:0]        o_inflight,
  output logic [NCH-1:0]        o_request,
  output logic [NCH-1:0]        o_access
);
  initial begin
    o_read_valid = '0;
    o_read_data  = '0;
    o_inflight   = '0;
    o_request    = '0;
    o_access     = '0;
  end
  // Released data shows the inverse so stale values never match
  task automatic read_word(input int ch, input logic [31:0] d);
    @(posedge i_clock);
    o_read_valid[ch] <= 1'b1;
    o_read_data[ch]  <= d;
    @(posedge i_clock);
    o_read_valid[ch] <= 1'b0;
    o_read_data[ch]  <= ~d;
  endtask
  task automatic pulse(input logic req, input int ch);
    @(posedge i_clock);
    if (req) begin
      o_request[ch] <= 1'b1;
    end else begin
      o_access[ch] <= 1'b1;
    end
    @(posedge i_clock);
    o_request <= '0;
    o_access  <= '0;
  endtask
  task automatic set_inflight(input int ch, input logic v);
    @(posedge i_clock);
    o_inflight[ch] <= v;
  endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the sniffer, abort and debug register block.
// Assumes a single AHB-Lite master and the channel model in dsad_chan_model.
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int NCH = 12;
  logic                clk = 1'b0;
  logic                rst_n;
  logic                hsel;
  logic                hwrite;
  logic [1:0]          htrans;
  logic [31:0]         haddr;
  logic [31:0]         hwdata;
  logic [7:0]          lv_r;
  logic [7:0]          lv_w;
  logic [7:0]          lv_t;
  wire logic           hready;
  wire logic           hresp;
  wire logic [31:0]    hrdata;
  wire logic [NCH-1:0] rv;
  wire logic [NCH-1:0] infl;
  wire logic [NCH-1:0] preq;
  wire logic [NCH-1:0] pacc;
  wire logic [NCH-1:0] abrt;
  wire logic [NCH-1:0] rstrt;
  wire logic [NCH-1:0][31:0] rdat;
  int                  error_cnt = 0;
  int                  cmp_count = 0;
  int                  ch;
  int                  k;
  int                  n;
  logic [31:0]         r;
  logic [31:0]         exp;
  logic [31:0]         d;
  logic [11:0]         ctl;
  logic [3:0]          codes [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'he, 4'hf, 4'h7};

  dsad_top #(.NCH(NCH)) u_dsad_top (
    .i_clock(clk), .i_arst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_chan_read_valid(rv), .i_chan_read_data(rdat),
    .i_read_addr_queue_level(lv_r), .i_write_addr_queue_level(lv_w),
    .i_transfer_data_queue_level(lv_t), .i_chan_inflight(infl),
    .o_channel_abort(abrt), .i_peripheral_request(preq),
    .i_chan_peripheral_access(pacc), .o_request_restart(rstrt));

  dsad_chan_model #(.NCH(NCH)) u_dsad_chan_model (
    .i_clock(clk), .o_read_valid(rv), .o_read_data(rdat), .o_inflight(infl),
    .o_request(preq), .o_access(pacc));

  always #2 clk = ~clk;

  function automatic logic [31:0] sniff(logic [31:0] a, logic [31:0] x, logic [3:0] c,
                                        logic bs);
    logic fb;
    if (bs) x = {<<8{x}};
    if (c == 4'h1 || c == 4'h3) x = {<<{x}};
    if (c == 4'h2 || c == 4'h3) a[31:16] = 16'h0000;
    for (int i = 31; i >= 0; i--) begin
      fb = (c[1] ? a[15] : a[31]) ^ x[i];
      if (c[3:1] == 3'h0) a = {a[30:0], 1'b0} ^ (fb ? dsad_pkg::CRC32_POLY : 32'h0);
      if (c[3:1] == 3'h1) a[15:0] = {a[14:0], 1'b0} ^ (fb ? dsad_pkg::CRC16_POLY : 16'h0);
    end
    if (c == 4'he) a = {31'h0, a[0] ^ (^x)};
    if (c == 4'hf) a = a + x;
    return a;
  endfunction

  function automatic logic [31:0] xform(logic [31:0] a, logic [11:0] c);
    if (c[10]) a = {<<{a}};
    if (c[11]) a = ~a;
    return a;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    end_sim;
  end

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0; hwdata = 32'h0;
    void'($urandom(32'he5c6));
    lv_r = 8'($urandom);
    lv_w = 8'($urandom);
    lv_t = 8'($urandom);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    ahb(1'b0, 32'h434, 32'h0, r); chk(r, 32'h0);
    ahb(1'b0, 32'h438, 32'h0, r); chk(r, 32'h0);
    ahb(1'b0, 32'h444, 32'h0, r); chk(r, 32'h0);
    ahb(1'b1, 32'h448, 32'hffffffff, r);
    ahb(1'b0, 32'h448, 32'h0, r); chk(r, 32'(NCH));
    ahb(1'b0, 32'h500, 32'h0, r); chk(r, 32'h0);
    ahb(1'b0, 32'h440, 32'h0, r); chk(r, {8'h0, lv_r, lv_w, lv_t});
    $display("test registers done");
    for (int p = 0; p < 2; p++) begin
      foreach (codes[i]) begin
        ch  = p ? $urandom_range(NCH - 1, 0) : 0;
        exp = $urandom;
        ctl = {2'b00, p[0], codes[i], ch[3:0], 1'b1};
        ahb(1'b1, 32'h434, {20'h0, ctl}, r);
        ahb(1'b1, 32'h438, exp, r);
        repeat (3) begin
          d = $urandom;
          u_dsad_chan_model.read_word(ch, d);
          exp = sniff(exp, d, codes[i], p[0]);
        end
        u_dsad_chan_model.read_word((ch + 1) % NCH, $urandom);
        ahb(1'b0, 32'h438, 32'h0, r); chk(r, exp);
        ctl = {2'($urandom_range(3, 1)), ctl[9:1], 1'b0};
        ahb(1'b1, 32'h434, {20'h0, ctl}, r);
        u_dsad_chan_model.read_word(ch, $urandom);
        ahb(1'b0, 32'h438, 32'h0, r); chk(r, xform(exp, ctl));
      end
    end
    $display("test sniffer done");
    u_dsad_chan_model.set_inflight(3, 1'b1);
    u_dsad_chan_model.set_inflight(0, 1'b1);
    ahb(1'b1, 32'h444, 32'h9, r);
    #1;
    chk({20'h0, abrt}, 32'h9);
    ahb(1'b0, 32'h444, 32'h0, r); chk(r, 32'h9);
    u_dsad_chan_model.set_inflight(3, 1'b0);
    u_dsad_chan_model.set_inflight(0, 1'b0);
    for (int i = 0; i < 10 && r !== 32'h0; i++) ahb(1'b0, 32'h444, 32'h0, r);
    chk(r, 32'h0);
    $display("test abort done");
    for (int j = 0; j < 3; j++) begin
      k = (j == 0) ? 0 : (j == 1) ? NCH - 1 : $urandom_range(NCH - 2, 1);
      n = $urandom_range(8, 3);
      repeat (n) u_dsad_chan_model.pulse(1'b1, k);
      repeat (2) u_dsad_chan_model.pulse(1'b0, k);
      ahb(1'b0, 32'h800 + 32'(k * 64), 32'h0, r); chk(r, 32'(n - 2));
      ahb(1'b1, 32'h800 + 32'(k * 64), $urandom, r);
      #1;
      chk({20'h0, rstrt}, 32'h1 << k);
      ahb(1'b0, 32'h800 + 32'(k * 64), 32'h0, r); chk(r, 32'h0);
    end
    $display("test request counters done");
    end_sim;
  end
endmodule
`default_nettype wire
